// ### common/dss_pkg.sv
package dss_pkg;

    // ****************************************
    // bus geometry and register offsets
    // ****************************************
    localparam int          DSS_ADDR_W        = 12;
    localparam int          DSS_DATA_W        = 32;
    localparam int          DSS_NCH           = 3;
    localparam int          DSS_NKIND         = 4;
    localparam int          DSS_FIFO_DEPTH    = 32;

    localparam logic [11:0] DSS_OFF_COMB_UP   = 12'h364;
    localparam logic [11:0] DSS_OFF_SRC_BST_L = 12'h368;
    localparam logic [11:0] DSS_OFF_SRC_BST_H = 12'h36C;
    localparam logic [11:0] DSS_OFF_DST_BST_L = 12'h370;
    localparam logic [11:0] DSS_OFF_DST_BST_H = 12'h374;
    localparam logic [11:0] DSS_OFF_SRC_SGL_L = 12'h378;
    localparam logic [11:0] DSS_OFF_SRC_SGL_H = 12'h37C;
    localparam logic [11:0] DSS_OFF_DST_SGL_L = 12'h380;
    localparam logic [11:0] DSS_OFF_DST_SGL_H = 12'h384;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int          DSS_REQ_LSB       = 0;
    localparam int          DSS_WEN_LSB       = 8;
    localparam logic [2:0]  DSS_REQ_RST       = 3'h0;
    localparam logic [31:0] DSS_RD_ZERO       = 32'h0000_0000;
    localparam logic [1:0]  DSS_HTRANS_NSEQ   = 2'h2;
    localparam logic [1:0]  DSS_HTRANS_SEQ    = 2'h3;
    localparam logic        DSS_HRESP_OKAY    = 1'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        DSS_KIND_SRC_BST = 2'b00,
        DSS_KIND_DST_BST = 2'b01,
        DSS_KIND_SRC_SGL = 2'b10,
        DSS_KIND_DST_SGL = 2'b11
    } dss_kind_type;

    typedef logic [DSS_NKIND-1:0][DSS_NCH-1:0] dss_req_type;

    typedef struct packed {
        dss_kind_type             kind;
        logic [DSS_NCH-1:0]       chans;
    } dss_evt_type;

endpackage

// ### design/dss_sw_handshake.sv

// ****************************************
// request event fifo
// ****************************************
module dss_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             valid_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid_o = valid_reg;
    assign count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            count_reg <= count_next;
        end
    end

    // head flag from its own flop so the output is registered
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= (count_next != '0);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    chk_fifo_bound:    assert property (count_reg <= (PW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    chk_fifo_valid:    assert property (out_valid_o == (count_reg != '0))
        else $error("fifo valid flag off its count");
    chk_fifo_hold:     assert property (
        (out_valid_o && !out_ready_i) |=> out_valid_o && $stable(out_data_o))
        else $error("fifo head changed while stalled");
    chk_fifo_pop:      assert property (
        (pop && !push) |=> count_reg == $past(count_reg) - (PW+1)'(1))
        else $error("fifo count did not fall on pop");
endmodule

// ****************************************
// software handshake request registers
// ****************************************
module dss_sw_handshake #(
    parameter int NCH        = dss_pkg::DSS_NCH,
    parameter int FIFO_DEPTH = dss_pkg::DSS_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                           mclk_i,
    input  wire logic                           resetn_i,
    // ahb slave
    input  wire logic                           hsel_i,
    input  wire logic [dss_pkg::DSS_ADDR_W-1:0] haddr_i,
    input  wire logic [1:0]                     htrans_i,
    input  wire logic                           hwrite_i,
    input  wire logic [2:0]                     hsize_i,
    input  wire logic [dss_pkg::DSS_DATA_W-1:0] hwdata_i,
    input  wire logic                           hready_i,
    output logic      [dss_pkg::DSS_DATA_W-1:0] hrdata_o,
    output logic                                hready_o,
    output logic                                hresp_o,
    // channel enables
    input  wire logic [NCH-1:0]                 chan_en_i,
    input  wire logic                           dma_en_i,
    input  wire logic [NCH-1:0]                 xfer_done_i,
    output logic      [NCH-1:0]                 chan_en_clr_o,
    // handshake side
    input  wire dss_pkg::dss_req_type           req_ack_i,
    output dss_pkg::dss_req_type                req_o,
    // request event stream
    output logic                                evt_valid_o,
    input  wire logic                           evt_ready_i,
    output dss_pkg::dss_evt_type                evt_data_o
);
    import dss_pkg::*;

    dss_req_type                req_reg;
    dss_req_type                req_next;
    logic                       pend_reg;
    dss_kind_type               wkind_reg;
    logic                       wreq_reg;
    logic                       hready_reg;
    logic [DSS_DATA_W-1:0]      hrdata_reg;
    logic [NCH-1:0]             clr_reg;
    logic [NCH-1:0]             ch_ok;
    logic [NCH-1:0]             wmask;
    logic [NCH-1:0]             set_mask;
    logic                       addr_ph;
    logic                       commit;
    logic                       fifo_in_ready;
    dss_evt_type                evt_in;

    // ****************************************
    // address decode
    // ****************************************
    // hit on one of the four lower request halves
    function automatic logic is_req_off(input logic [DSS_ADDR_W-1:0] a);
        is_req_off = (a == DSS_OFF_SRC_BST_L) || (a == DSS_OFF_DST_BST_L) ||
                     (a == DSS_OFF_SRC_SGL_L) || (a == DSS_OFF_DST_SGL_L);
    endfunction

    function automatic dss_kind_type kind_of(input logic [DSS_ADDR_W-1:0] a);
        unique case (a)
            DSS_OFF_DST_BST_L: kind_of = DSS_KIND_DST_BST;
            DSS_OFF_SRC_SGL_L: kind_of = DSS_KIND_SRC_SGL;
            DSS_OFF_DST_SGL_L: kind_of = DSS_KIND_DST_SGL;
            default:           kind_of = DSS_KIND_SRC_BST;
        endcase
    endfunction

    assign addr_ph = hsel_i && hready_i && !pend_reg &&
                     (htrans_i == DSS_HTRANS_NSEQ || htrans_i == DSS_HTRANS_SEQ);

    // ****************************************
    // write gating
    // ****************************************
    assign ch_ok    = chan_en_i & {NCH{dma_en_i}} & ~xfer_done_i;
    assign wmask    = hwdata_i[DSS_WEN_LSB +: NCH] & ch_ok;
    assign set_mask = wmask & hwdata_i[DSS_REQ_LSB +: NCH] & ~req_reg[wkind_reg];
    // stall while newly set bits cannot enter a full fifo
    assign commit   = pend_reg && (set_mask == '0 || fifo_in_ready);
    assign evt_in   = '{kind: wkind_reg, chans: set_mask};

    always_comb begin
        req_next = req_reg & ~req_ack_i;
        if (commit && wreq_reg) begin
            req_next[wkind_reg] = (req_next[wkind_reg] & ~wmask) |
                                  (hwdata_i[DSS_REQ_LSB +: NCH] & wmask);
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_reg <= '{default: DSS_REQ_RST};
        end else begin
            req_reg <= req_next;
        end
    end

    // ****************************************
    // bus phases
    // ****************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_reg   <= 1'b0;
            wreq_reg   <= 1'b0;
            wkind_reg  <= DSS_KIND_SRC_BST;
            hready_reg <= 1'b1;
        end else if (addr_ph && hwrite_i) begin
            pend_reg   <= 1'b1;
            hready_reg <= 1'b0;
            wreq_reg   <= is_req_off(haddr_i);
            wkind_reg  <= kind_of(haddr_i);
        end else if (commit) begin
            pend_reg   <= 1'b0;
            hready_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_reg <= DSS_RD_ZERO;
        end else if (addr_ph && !hwrite_i) begin
            hrdata_reg <= DSS_RD_ZERO;
            unique case (haddr_i)
                DSS_OFF_SRC_BST_L: hrdata_reg[DSS_REQ_LSB +: NCH] <= req_reg[DSS_KIND_SRC_BST];
                DSS_OFF_DST_BST_L: hrdata_reg[DSS_REQ_LSB +: NCH] <= req_reg[DSS_KIND_DST_BST];
                DSS_OFF_SRC_SGL_L: hrdata_reg[DSS_REQ_LSB +: NCH] <= req_reg[DSS_KIND_SRC_SGL];
                DSS_OFF_DST_SGL_L: hrdata_reg[DSS_REQ_LSB +: NCH] <= req_reg[DSS_KIND_DST_SGL];
                default:           hrdata_reg <= DSS_RD_ZERO;
            endcase
        end
    end

    // ****************************************
    // channel enable clear
    // ****************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clr_reg <= '0;
        end else begin
            clr_reg <= xfer_done_i | {NCH{~dma_en_i}};
        end
    end

    dss_fifo #(
        .WIDTH ($bits(dss_evt_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (commit && wreq_reg && set_mask != '0),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (evt_in),
        .out_valid_o (evt_valid_o),
        .out_ready_i (evt_ready_i),
        .out_data_o  (evt_data_o)
    );

    assign hrdata_o      = hrdata_reg;
    assign hready_o      = hready_reg;
    assign hresp_o       = DSS_HRESP_OKAY;
    assign chan_en_clr_o = clr_reg;
    assign req_o         = req_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    property p_gate(k);
        (commit && wreq_reg && wkind_reg == k && req_ack_i == '0) |=>
            req_reg[k] == (($past(req_reg[k]) & ~$past(wmask)) |
                           ($past(hwdata_i[DSS_REQ_LSB +: NCH]) & $past(wmask)));
    endproperty

    chk_src_bst_gate:  assert property (p_gate(DSS_KIND_SRC_BST))
        else $error("source burst request gating wrong");
    chk_dst_bst_gate:  assert property (p_gate(DSS_KIND_DST_BST))
        else $error("destination burst request gating wrong");
    chk_src_sgl_gate:  assert property (p_gate(DSS_KIND_SRC_SGL))
        else $error("source single request gating wrong");
    chk_dst_sgl_gate:  assert property (p_gate(DSS_KIND_DST_SGL))
        else $error("destination single request gating wrong");
    chk_no_wen_hold:   assert property (
        (commit && hwdata_i[DSS_WEN_LSB +: NCH] == '0 && req_ack_i == '0) |=>
            $stable(req_reg)) else $error("write without enable changed a request");
    chk_dst_sgl_read:  assert property (
        (addr_ph && !hwrite_i && haddr_i == DSS_OFF_DST_SGL_L) |=>
            hrdata_o == {29'h0, $past(req_reg[DSS_KIND_DST_SGL])})
        else $error("destination single readback wrong");
    chk_comb_up_zero:  assert property (
        (addr_ph && !hwrite_i && haddr_i == DSS_OFF_COMB_UP) |=> hrdata_o == DSS_RD_ZERO)
        else $error("combined status upper half not zero");
    chk_upper_ignore:  assert property (
        (commit && !wreq_reg && req_ack_i == '0) |=> $stable(req_reg))
        else $error("reserved half write changed a request");
    chk_done_clears:   assert property (
        xfer_done_i != '0 |=> (chan_en_clr_o & $past(xfer_done_i)) == $past(xfer_done_i))
        else $error("finished channel enable not cleared");
    chk_global_block:  assert property (
        (!dma_en_i && req_ack_i == '0) |=> $stable(req_reg) && chan_en_clr_o == '1)
        else $error("request changed with global enable off");
    chk_req_holds:     assert property (
        (!pend_reg && req_ack_i == '0) |=> $stable(req_reg))
        else $error("request changed without write or ack");
    chk_backpressure:  assert property (
        (pend_reg && !commit) |-> !hready_o)
        else $error("write completed while fifo full");
    chk_read_no_wait:  assert property (
        (addr_ph && !hwrite_i) |=> hready_o)
        else $error("read inserted a wait state");
    chk_write_waits:   assert property (
        (addr_ph && hwrite_i) |=> !hready_o && pend_reg)
        else $error("write did not enter its data phase");
    chk_stall_holds:   assert property (
        (pend_reg && !commit) |=> pend_reg && $stable(wkind_reg))
        else $error("stalled write lost its target");
    chk_wen_read:      assert property (
        (addr_ph && !hwrite_i) |=> hrdata_o[DSS_WEN_LSB +: NCH] == '0)
        else $error("write enable bits read back");
    chk_upper_read:    assert property (
        (addr_ph && !hwrite_i && haddr_i == DSS_OFF_DST_SGL_H) |=> hrdata_o == DSS_RD_ZERO)
        else $error("reserved upper half not zero");
    chk_ack_clears:    assert property (
        (req_ack_i != '0 && !commit) |=> (req_o & $past(req_ack_i)) == '0)
        else $error("acknowledged request not cleared");
    chk_done_blocks:   assert property (
        (xfer_done_i != '0 && req_ack_i == '0) |=>
            ((req_reg ^ $past(req_reg)) & {DSS_NKIND{$past(xfer_done_i)}}) == '0)
        else $error("write reached a finishing channel");
    chk_evt_pushed:    assert property (
        (commit && wreq_reg && set_mask != '0 && !evt_valid_o) |=>
            evt_valid_o && evt_data_o == $past(evt_in))
        else $error("new request event not queued");

    cov_req_set:    cover property (commit && set_mask != '0);
    cov_fifo_stall: cover property (pend_reg && !fifo_in_ready ##1 commit);
    cov_ack_clear:  cover property (req_reg != '0 ##1 req_reg == '0);
    cov_dma_off:    cover property (commit && wreq_reg && !dma_en_i);
    cov_req_read:   cover property (addr_ph && !hwrite_i && haddr_i == DSS_OFF_SRC_SGL_L);
endmodule

// ### tb/dss_cpu_model.sv
// ****************************************
// bus master standing in for cpu software
// ****************************************
module dss_cpu_model
    import dss_pkg::*;
(
    // clock
    input  wire logic        mclk_i,
    // slave answer
    input  wire logic        rdy_i,
    input  wire logic [31:0] rdata_i,
    // request lines
    output logic             sel_o,
    output logic [11:0]      addr_o,
    output logic [1:0]       trans_o,
    output logic             write_o,
    output logic [31:0]      wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sel_o = 1'h0;
        addr_o = 12'h000;
        trans_o = 2'h0;
        write_o = 1'h0;
        wdata_o = 32'h0;
    end

    // software sets the enable together with the value
    function automatic logic [31:0] req_word(input logic [2:0] req, input logic [2:0] wen);
        return {21'h0, wen, 5'h0, req};
    endfunction

    // one transfer; held until a rising edge samples ready high or 60 more rising edges pass
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        @(negedge mclk_i);
        sel_o = 1'h1;
        trans_o = DSS_HTRANS_NSEQ;
        write_o = w;
        addr_o = a;
        @(posedge mclk_i);
        @(negedge mclk_i);
        sel_o = 1'h0;
        trans_o = 2'h0;
        wdata_o = d;
        @(posedge mclk_i);
        while (rdy_i !== 1'h1 && n < 60) begin
            @(posedge mclk_i);
            n++;
        end
        r = rdata_i;
        @(negedge mclk_i);
    endtask
endmodule

// ### tb/dss_sw_handshake_tb.sv
module dss_sw_handshake_tb
    import dss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk_i, resetn_i, hsel_i, hwrite_i, hready_o, hresp_o;
    logic        dma_en_i, evt_valid_o, evt_ready_i, drain;
    logic [11:0] haddr_i;
    logic [1:0]  htrans_i;
    logic [31:0] hwdata_i, hrdata_o, rd;
    logic [2:0]  chan_en_i, xfer_done_i, chan_en_clr_o;
    dss_req_type req_ack_i, req_o, em;
    dss_evt_type evt_data_o;
    int          n_fail, samples_checked, pops, k;

    dss_sw_handshake #(.NCH(3), .FIFO_DEPTH(32)) uut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hready_o), .hrdata_o(hrdata_o), .hready_o(hready_o), .hresp_o(hresp_o),
        .chan_en_i(chan_en_i), .dma_en_i(dma_en_i), .xfer_done_i(xfer_done_i),
        .chan_en_clr_o(chan_en_clr_o), .req_ack_i(req_ack_i), .req_o(req_o),
        .evt_valid_o(evt_valid_o), .evt_ready_i(evt_ready_i), .evt_data_o(evt_data_o));

    dss_cpu_model host (
        .mclk_i(mclk_i), .rdy_i(hready_o), .rdata_i(hrdata_o), .sel_o(hsel_i),
        .addr_o(haddr_i), .trans_o(htrans_i), .write_o(hwrite_i), .wdata_o(hwdata_i));

    initial begin
        mclk_i = 1'h0;
        forever #10 mclk_i = ~mclk_i;
    end

    // drain side stalls at random while draining
    always @(negedge mclk_i) evt_ready_i <= drain & 1'($urandom);
    always @(posedge mclk_i) pops <= pops + int'(evt_valid_o && evt_ready_i);

    function automatic logic [2:0] upd(input logic [2:0] old, input logic [31:0] d,
                                       input logic [2:0] ce, input logic de);
        for (int c = 0; c < 3; c++) begin
            if (d[8+c] && ce[c] && de) old[c] = d[c];
        end
        return old;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        host.xfer(1'h0, a, 32'h0, rd);
        chk(rd, e);
        chk(32'(hresp_o), 32'h0);
    endtask

    task automatic wrk(input int q, input logic [31:0] d);
        host.xfer(1'h1, DSS_OFF_SRC_BST_L + 12'(8 * q), d, rd);
        em[q] = upd(em[q], d, chan_en_i, dma_en_i);
        chk(32'(req_o), 32'(em));
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h2EEAA9F8));
        {resetn_i, dma_en_i, drain, pops, n_fail, samples_checked} = '0;
        {chan_en_i, xfer_done_i, req_ack_i, em} = '0;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        resetn_i = 1'h1;
        dma_en_i = 1'h1;
        chan_en_i = 3'h7;
        for (int i = 0; i < 9; i++) rdc(DSS_OFF_COMB_UP + 12'(4 * i), DSS_RD_ZERO);
        for (int i = 0; i < 5; i++) host.xfer(1'h1, DSS_OFF_COMB_UP + 12'(8 * i), '1, rd);
        for (int i = 0; i < 5; i++) rdc(DSS_OFF_COMB_UP + 12'(8 * i), DSS_RD_ZERO);
        rdc(12'h388, DSS_RD_ZERO);
        chk(32'(req_o), 32'h0);
        $display("reserved test done");
        for (int q = 0; q < 4; q++) wrk(q, host.req_word(3'h7, 3'h1 << (q % 3)));
        chk(32'(evt_data_o), 32'({DSS_KIND_SRC_BST, 3'h1}));
        for (int q = 0; q < 4; q++) rdc(DSS_OFF_SRC_BST_L + 12'(8 * q), 32'(em[q]));
        @(negedge mclk_i);
        req_ack_i = em;
        em = '0;
        @(negedge mclk_i);
        req_ack_i = '0;
        chk(32'(req_o), 32'h0);
        $display("request test done");
        for (int i = 4; i < 32; i++) begin
            wrk(0, host.req_word(3'h1, 3'h1));
            wrk(0, host.req_word(3'h0, 3'h1));
        end
        fork
            wrk(0, host.req_word(3'h1, 3'h1));
            begin
                repeat (8) @(negedge mclk_i);
                chk(32'(hready_o), 32'h0);
                pops = 0;
                drain = 1'h1;
            end
        join
        repeat (150) @(negedge mclk_i);
        chk(32'(pops), 32'd33);
        chk(32'(evt_valid_o), 32'h0);
        $display("buffer test done");
        xfer_done_i = 3'h2;
        @(negedge mclk_i);
        xfer_done_i = 3'h0;
        chk(32'(chan_en_clr_o), 32'h2);
        dma_en_i = 1'h0;
        @(negedge mclk_i);
        chk(32'(chan_en_clr_o), 32'h7);
        wrk(1, host.req_word(3'h7, 3'h7));
        dma_en_i = 1'h1;
        $display("enable test done");
        repeat (80) begin
            chan_en_i = 3'($urandom);
            k = $urandom % 4;
            wrk(k, $urandom);
            rdc(DSS_OFF_SRC_BST_L + 12'(8 * k), 32'(em[k]));
        end
        $display("random test done");
        finish_test();
    end
endmodule
